// ### led_startup_seq.sv
/*
 * Start-up and fault sequencer of a four-channel LED boost driver.
 * Assumes all level inputs are comparator outputs, asynchronous to MCLK_IN,
 * and that SYNC_CLK_IN is the external sync clock seen on the frequency-set pin.
 */
// Function
// RQ1: Start needs enable pulse and supply above lockout.
// RQ2: System check before any LED sink enabled.
// RQ3: No power-up while frequency-set pin held low.
// RQ4: Dimming low 32750 ticks enters low power.
// RQ5: Supply below falling lockout enters low power.
// RQ6: Gate first, detect after gate ready.
// RQ7: Wait 3000-4000 ticks before classifying pins.
// RQ8: Classify pins shorted, unused or in use.
// RQ9: Unused pins dropped from regulation.
// RQ10: Shorted pin holds soft-start, then re-checked.
// RQ11: Soft-start only above output undervoltage threshold.
// RQ12: Output undervoltage shuts down, retries, no latch.
// RQ13: Overcurrent latches off until long dimming low.
// RQ14: Soft-start ends on target, near-OUTPUT_SENSE_PIN or timeout.
// RQ15: Frequency-set short to ground shuts down.
// RQ16: Start only with pin floated high or sync.
// RQ17: Host sync phases each at least 150 ns; host_ctl_model drives 40 ns phases.
// RQ18: Host keeps sync duty within allowed band.
// RQ19: Sync open falls back to oscillator, no fault.
// RQ20: Sync stuck low faults after 10 us.
// RQ21: Counts run on the active switching clock.
`timescale 1ns/1ps
`include "led_seq_defines.svh"

module led_startup_seq #(
    parameter logic [`CNT_W-1:0] DIM_OFF_TICKS = `DIM_OFF_TICKS,
    parameter logic [`CNT_W-1:0] SS_TICKS      = `SS_TICKS
) (
    input  wire logic                    MCLK_IN,
    input  wire logic                    RSTN_IN,
    input  wire logic                    SYNC_CLK_IN,
    input  wire logic                    DIM_IN,
    input  wire logic                    SUPPLY_START_OK_IN,
    input  wire logic                    SUPPLY_STOP_LOW_IN,
    input  wire logic                    FREQ_SET_HIGH_IN,
    input  wire logic                    GATE_READY_IN,
    input  wire logic                    OUT_ABOVE_UV_IN,
    input  wire logic                    OUT_NEAR_OVP_IN,
    input  wire logic                    IN_OVERCURRENT_IN,
    input  wire led_seq_pkg::led_sense_t LED_SENSE_IN,
    output logic                         GATE_ON_OUT,
    output logic                         SWITCH_EN_OUT,
    output logic                         SOFT_START_OUT,
    output logic                         LOW_POWER_OUT,
    output logic                         FAULT_N_OUT,
    output logic                         SYNC_ACTIVE_OUT,
    output logic [`LED_N-1:0]            LED_IN_USE_OUT,
    output logic [`LED_N-1:0]            LED_SINK_EN_OUT
);
    import led_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: toggle per rising sync edge

    logic tog_r;
    logic tog_nxt;

    always_comb begin
        tog_nxt = ~tog_r;
    end

    always_ff @(posedge SYNC_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            tog_r <= 1'b0;
        end else begin
            tog_r <= tog_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    localparam int MISC_W = 9;
    logic [MISC_W-1:0] misc_raw;
    logic [MISC_W-1:0] misc_s1_r;
    logic [MISC_W-1:0] misc_s2_r;
    led_sense_t        led_s1_r;
    led_sense_t        led_s2_r;
    logic              tog_s1_r;
    logic              tog_s2_r;
    logic              tog_s3_r;

    assign misc_raw = {DIM_IN, SUPPLY_START_OK_IN, SUPPLY_STOP_LOW_IN, FREQ_SET_HIGH_IN,
                       GATE_READY_IN, OUT_ABOVE_UV_IN, OUT_NEAR_OVP_IN,
                       IN_OVERCURRENT_IN, 1'b0};

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            misc_s1_r <= '0;
            misc_s2_r <= '0;
            led_s1_r  <= '0;
            led_s2_r  <= '0;
            tog_s1_r  <= 1'b0;
            tog_s2_r  <= 1'b0;
            tog_s3_r  <= 1'b0;
        end else begin
            misc_s1_r <= misc_raw;
            misc_s2_r <= misc_s1_r;
            led_s1_r  <= LED_SENSE_IN;
            led_s2_r  <= led_s1_r;
            tog_s1_r  <= tog_r;
            tog_s2_r  <= tog_s1_r;
            tog_s3_r  <= tog_s2_r;
        end
    end

    logic dim;
    logic sup_start_ok;
    logic sup_stop_low;
    logic freq_set_high;
    logic gate_ready;
    logic out_above_uv;
    logic out_near_ovp;
    logic overcurrent;
    logic sync_tick;

    assign {dim, sup_start_ok, sup_stop_low, freq_set_high, gate_ready, out_above_uv,
            out_near_ovp, overcurrent} = misc_s2_r[MISC_W-1:1];
    assign sync_tick = tog_s2_r ^ tog_s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // Switching clock source and frequency-set pin watch

    logic [`OSC_W-1:0] osc_cnt_r;
    logic [`OSC_W-1:0] osc_cnt_nxt;
    logic [`TMR_W-1:0] loss_cnt_r;
    logic [`TMR_W-1:0] loss_cnt_nxt;
    logic [`TMR_W-1:0] low_cnt_r;
    logic [`TMR_W-1:0] low_cnt_nxt;
    logic              sync_act_r;
    logic              sync_act_nxt;
    logic              osc_tick;
    logic              sw_tick;
    logic              freq_set_fault;
    logic              freq_set_ok;

    always_comb begin
        osc_tick     = (osc_cnt_r == `OSC_DIV - 7'h01);
        osc_cnt_nxt  = osc_tick ? '0 : osc_cnt_r + 7'h01;
        loss_cnt_nxt = loss_cnt_r;
        sync_act_nxt = sync_act_r;
        if (sync_tick) begin
            loss_cnt_nxt = '0;
            sync_act_nxt = 1'b1;
        end else if (loss_cnt_r != `TMR_W'(`SYNC_LOSS_CYC)) begin
            loss_cnt_nxt = loss_cnt_r + `TMR_W'(1);
        end else begin
            sync_act_nxt = 1'b0;                               // [RQ19]
        end
        low_cnt_nxt = low_cnt_r;
        if (freq_set_high || sync_tick) begin
            low_cnt_nxt = '0;
        end else if (low_cnt_r != `TMR_W'(`PIN_SHORT_CYC)) begin
            low_cnt_nxt = low_cnt_r + `TMR_W'(1);
        end
    end

    assign sw_tick        = sync_act_r ? sync_tick : osc_tick;     // [RQ21]
    assign freq_set_fault = (low_cnt_r == `TMR_W'(`PIN_SHORT_CYC)); // [RQ20]
    assign freq_set_ok    = freq_set_high || sync_act_r;           // [RQ3] [RQ16]

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            osc_cnt_r  <= '0;
            loss_cnt_r <= '0;
            low_cnt_r  <= '0;
            sync_act_r <= 1'b0;
        end else begin
            osc_cnt_r  <= osc_cnt_nxt;
            loss_cnt_r <= loss_cnt_nxt;
            low_cnt_r  <= low_cnt_nxt;
            sync_act_r <= sync_act_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    seq_state_t        state_r;
    seq_state_t        state_nxt;
    logic [`CNT_W-1:0] dim_cnt_r;
    logic [`CNT_W-1:0] dim_cnt_nxt;
    logic [`CNT_W-1:0] ss_cnt_r;
    logic [`CNT_W-1:0] ss_cnt_nxt;
    logic [`DET_W-1:0] det_cnt_r;
    logic [`DET_W-1:0] det_cnt_nxt;
    logic [1:0]        en_cnt_r;
    logic [1:0]        en_cnt_nxt;
    logic [`LED_N-1:0] used_r;
    logic [`LED_N-1:0] used_nxt;
    seq_ctl_t          ctl_r;
    seq_ctl_t          ctl_nxt;
    logic [`LED_N-1:0] sink_r;
    logic [`LED_N-1:0] sink_nxt;
    logic              dim_off;
    logic              any_short;
    logic              pins_up;
    logic              ss_done;

    function automatic seq_ctl_t decode_ctl(input seq_state_t st);
        seq_ctl_t c;
        c            = '0;
        c.fault_n    = (st != ST_PIN_FAULT) && (st != ST_OC_LATCH);
        c.low_power  = (st == ST_SHUTDOWN);
        c.gate_on    = (st != ST_SHUTDOWN) && (st != ST_OC_LATCH) && (st != ST_PIN_FAULT);
        c.soft_start = (st == ST_SOFT_START);
        c.switch_en  = (st == ST_SOFT_START) || (st == ST_RUN);
        return c;
    endfunction

    always_comb begin
        any_short = |led_s2_r.short_gnd;
        pins_up   = &led_s2_r.above_det;
        dim_off   = (dim_cnt_r >= DIM_OFF_TICKS);
        ss_done   = (&(led_s2_r.at_target | ~used_r)) || out_near_ovp
                    || (ss_cnt_r >= SS_TICKS);                 // [RQ14]
        dim_cnt_nxt = dim_cnt_r;
        if (dim) begin
            dim_cnt_nxt = '0;
        end else if (sw_tick && !dim_off) begin
            dim_cnt_nxt = dim_cnt_r + `CNT_W'(1);
        end
        en_cnt_nxt = en_cnt_r;
        if (!dim) begin
            en_cnt_nxt = '0;
        end else if (sw_tick && en_cnt_r != `ENABLE_MIN_TICKS) begin
            en_cnt_nxt = en_cnt_r + 2'h1;
        end
        state_nxt   = state_r;
        det_cnt_nxt = det_cnt_r;
        ss_cnt_nxt  = '0;
        used_nxt    = used_r;
        if (sup_stop_low) begin
            state_nxt = ST_SHUTDOWN;                           // [RQ5]
        end else if (state_r != ST_SHUTDOWN && dim_off) begin
            state_nxt = ST_SHUTDOWN;                           // [RQ4] [RQ13]
        end else if (state_r != ST_SHUTDOWN && state_r != ST_OC_LATCH && overcurrent) begin
            state_nxt = ST_OC_LATCH;                           // [RQ13]
        end else if (state_r != ST_SHUTDOWN && state_r != ST_OC_LATCH
                     && state_r != ST_PIN_FAULT && freq_set_fault) begin
            state_nxt = ST_PIN_FAULT;                          // [RQ15] [RQ20]
        end else begin
            case (state_r)
                ST_SHUTDOWN: begin
                    if (dim && en_cnt_r == `ENABLE_MIN_TICKS && sup_start_ok && freq_set_ok) begin
                        state_nxt = ST_GATE_UP;                // [RQ1] [RQ3] [RQ16]
                    end
                end
                ST_GATE_UP: begin
                    det_cnt_nxt = '0;
                    if (gate_ready) begin
                        state_nxt = ST_DETECT;                 // [RQ6]
                    end
                end
                ST_DETECT: begin
                    if (any_short || !pins_up) begin
                        det_cnt_nxt = '0;                      // [RQ10]
                    end else if (det_cnt_r == `DET_WAIT_TICKS) begin
                        used_nxt  = led_s2_r.in_use;           // [RQ8]
                        state_nxt = ST_UV_CHECK;               // [RQ2] [RQ7]
                    end else if (sw_tick) begin
                        det_cnt_nxt = det_cnt_r + `DET_W'(1);
                    end
                end
                ST_UV_CHECK: begin
                    if (out_above_uv) begin
                        state_nxt = ST_SOFT_START;             // [RQ11]
                    end
                end
                ST_SOFT_START: begin
                    ss_cnt_nxt = ss_cnt_r + (sw_tick ? `CNT_W'(1) : `CNT_W'(0));
                    if (!out_above_uv) begin
                        state_nxt = ST_UV_CHECK;               // [RQ12]
                    end else if (ss_done) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!out_above_uv) begin
                        state_nxt = ST_UV_CHECK;               // [RQ12]
                    end
                end
                ST_OC_LATCH: begin
                    state_nxt = ST_OC_LATCH;
                end
                ST_PIN_FAULT: begin
                    if (freq_set_ok && !freq_set_fault) begin
                        state_nxt = out_above_uv ? ST_SOFT_START : ST_UV_CHECK; // [RQ20] [RQ11]
                    end
                end
                default: begin
                    state_nxt = ST_SHUTDOWN;
                end
            endcase
        end
        ctl_nxt  = decode_ctl(state_nxt);
        sink_nxt = (ctl_nxt.switch_en && dim) ? used_nxt : '0; // [RQ2] [RQ9]
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_r   <= ST_SHUTDOWN;
            dim_cnt_r <= '0;
            ss_cnt_r  <= '0;
            det_cnt_r <= '0;
            en_cnt_r  <= '0;
            used_r    <= '0;
            ctl_r     <= 5'h03;
            sink_r    <= '0;
        end else begin
            state_r   <= state_nxt;
            dim_cnt_r <= dim_cnt_nxt;
            ss_cnt_r  <= ss_cnt_nxt;
            det_cnt_r <= det_cnt_nxt;
            en_cnt_r  <= en_cnt_nxt;
            used_r    <= used_nxt;
            ctl_r     <= ctl_nxt;
            sink_r    <= sink_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign GATE_ON_OUT     = ctl_r.gate_on;
    assign SWITCH_EN_OUT   = ctl_r.switch_en;
    assign SOFT_START_OUT  = ctl_r.soft_start;
    assign LOW_POWER_OUT   = ctl_r.low_power;
    assign FAULT_N_OUT     = ctl_r.fault_n;
    assign SYNC_ACTIVE_OUT = sync_act_r;
    assign LED_IN_USE_OUT  = used_r;
    assign LED_SINK_EN_OUT = sink_r;

endmodule

// ### led_seq_defines.svh
/*
 * Constants of the LED driver start-up and fault sequencer.
 * Assumes a 200 MHz system clock; counts marked TICKS run on the switching clock.
 */
`ifndef LED_SEQ_DEFINES_SVH
`define LED_SEQ_DEFINES_SVH

`define MCLK_NS          5
`define SYNC_LOSS_NS     5000
`define PIN_SHORT_NS     10000
`define SYNC_LOSS_CYC    (`SYNC_LOSS_NS / `MCLK_NS)
`define PIN_SHORT_CYC    (`PIN_SHORT_NS / `MCLK_NS)
`define TMR_W            11
`define OSC_DIV          7'h64
`define OSC_W            7
`define ENABLE_MIN_TICKS 2'h1
`define DET_WAIT_TICKS   12'hDAC
`define DET_W            12
`define DIM_OFF_TICKS    16'h7FEE
`define SS_TICKS         16'h4000
`define CNT_W            16
`define LED_N            4

`endif

// ### led_seq_pkg.sv
/*
 * Types of the LED driver start-up and fault sequencer.
 * Assumes led_seq_defines.svh is on the include path.
 */
`include "led_seq_defines.svh"

package led_seq_pkg;

    typedef enum logic [2:0] {
        ST_SHUTDOWN   = 3'b000,
        ST_GATE_UP    = 3'b001,
        ST_DETECT     = 3'b010,
        ST_UV_CHECK   = 3'b011,
        ST_SOFT_START = 3'b100,
        ST_RUN        = 3'b101,
        ST_OC_LATCH   = 3'b110,
        ST_PIN_FAULT  = 3'b111
    } seq_state_t;

    // Per-pin comparator results of the LED sinks
    typedef struct packed {
        logic [`LED_N-1:0] above_det;
        logic [`LED_N-1:0] short_gnd;
        logic [`LED_N-1:0] in_use;
        logic [`LED_N-1:0] at_target;
    } led_sense_t;

    typedef struct packed {
        logic gate_on;
        logic switch_en;
        logic soft_start;
        logic low_power;
        logic fault_n;
    } seq_ctl_t;

endpackage

// ### led_seq_props.sv
/*
 * Checker for the LED driver start-up and fault sequencer.
 * Sees only the top ports; bound to led_startup_seq at the foot of this file.
 */
`timescale 1ns/1ps
`include "led_seq_defines.svh"

module led_seq_props #(
    parameter logic [`CNT_W-1:0] DIM_OFF_TICKS = `DIM_OFF_TICKS,
    parameter logic [`CNT_W-1:0] SS_TICKS      = `SS_TICKS
) (
    input wire logic              MCLK_IN,
    input wire logic              RSTN_IN,
    input wire logic              SYNC_CLK_IN,
    input wire logic              DIM_IN,
    input wire logic              SUPPLY_STOP_LOW_IN,
    input wire logic              FREQ_SET_HIGH_IN,
    input wire logic              OUT_ABOVE_UV_IN,
    input wire logic              OUT_NEAR_OVP_IN,
    input wire logic              IN_OVERCURRENT_IN,
    input wire logic              GATE_ON_OUT,
    input wire logic              SWITCH_EN_OUT,
    input wire logic              SOFT_START_OUT,
    input wire logic              LOW_POWER_OUT,
    input wire logic              FAULT_N_OUT,
    input wire logic              SYNC_ACTIVE_OUT,
    input wire logic [`LED_N-1:0] LED_IN_USE_OUT,
    input wire logic [`LED_N-1:0] LED_SINK_EN_OUT
);
    logic [2:0]  sync_r;
    int unsigned idle_r;
    int unsigned freq_set_lo_r;
    int unsigned dim_low_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Sync edge age and low-level run lengths in system cycles
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sync_r <= 3'h0;
            idle_r <= 32'h0;
            freq_set_lo_r <= 32'h0;
            dim_low_r <= 32'h0;
        end else begin
            sync_r <= {sync_r[1:0], SYNC_CLK_IN};
            idle_r <= (sync_r[1] && !sync_r[2]) ? 32'h0 : idle_r + ((idle_r < 32'h186A0) ? 1 : 0);
            freq_set_lo_r <= FREQ_SET_HIGH_IN ? 32'h0 : freq_set_lo_r + 1;
            dim_low_r <= DIM_IN ? 32'h0 : dim_low_r + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence uv_lost_s;    !OUT_ABOVE_UV_IN [*5];   endsequence
    sequence ovp_hold_s;   OUT_NEAR_OVP_IN [*5];    endsequence
    sequence supply_cut_s; SUPPLY_STOP_LOW_IN [*5]; endsequence

    sink_gate_a: assert property (LED_SINK_EN_OUT != 4'h0 |-> SWITCH_EN_OUT
        && (LED_SINK_EN_OUT & ~LED_IN_USE_OUT) == 4'h0) else $error("sinks on out of order");
    uv_start_a: assert property ($rose(SWITCH_EN_OUT) |-> $past(OUT_ABOVE_UV_IN, 2)
        && GATE_ON_OUT) else $error("switching began without output voltage");
    uv_drop_a: assert property (uv_lost_s |=> !SWITCH_EN_OUT)
        else $error("switching kept after output undervoltage");
    oc_latch_a: assert property ($rose(IN_OVERCURRENT_IN) && SWITCH_EN_OUT
        |-> ##[1:6] !FAULT_N_OUT) else $error("overcurrent not latched");
    supply_low_a: assert property (supply_cut_s |=> LOW_POWER_OUT)
        else $error("no shutdown on supply cut");
    dim_off_a: assert property (dim_low_r > 32'(DIM_OFF_TICKS) * 100 + 1200 |-> LOW_POWER_OUT)
        else $error("no shutdown after long dimming low");
    ss_ovp_a: assert property (ovp_hold_s |=> !SOFT_START_OUT)
        else $error("soft start kept near overvoltage");
    sync_fall_a: assert property (idle_r == 1300 && FREQ_SET_HIGH_IN |-> !SYNC_ACTIVE_OUT
        && FAULT_N_OUT) else $error("sync loss handled wrongly");
    pin_fault_a: assert property (freq_set_lo_r == 2300 && idle_r > 2300
        && !LOW_POWER_OUT |-> !FAULT_N_OUT && !SWITCH_EN_OUT)
        else $error("held-low pin not faulted");
endmodule

bind led_startup_seq led_seq_props #(.DIM_OFF_TICKS(DIM_OFF_TICKS), .SS_TICKS(SS_TICKS)) u_props (
    .MCLK_IN, .RSTN_IN, .SYNC_CLK_IN, .DIM_IN, .SUPPLY_STOP_LOW_IN, .FREQ_SET_HIGH_IN,
    .OUT_ABOVE_UV_IN, .OUT_NEAR_OVP_IN, .IN_OVERCURRENT_IN, .GATE_ON_OUT, .SWITCH_EN_OUT,
    .SOFT_START_OUT, .LOW_POWER_OUT, .FAULT_N_OUT, .SYNC_ACTIVE_OUT, .LED_IN_USE_OUT,
    .LED_SINK_EN_OUT);

// ### host_ctl_model.sv
/*
 * Host controller model: dimming level and external sync clock.
 * Assumes the bench requests dimming and sync; sync stands low when stopped.
 */
`timescale 1ns/1ps

module host_ctl_model (
    input  wire logic sync_on_in,
    input  wire logic dim_req_in,
    output logic      sync_clk_out,
    output logic      dim_out
);
    assign dim_out = dim_req_in;

    // 80 ns period, even duty, phase unrelated to the system clock
    initial begin
        sync_clk_out = 1'b0;
        #13.7;
        forever begin
            #40 sync_clk_out = sync_on_in ? ~sync_clk_out : 1'b0;
        end
    end
endmodule

// ### tb_led_driver_startup_fault_sequencer.sv
/*
 * Self-checking bench of the LED driver start-up and fault sequencer.
 * Assumes led_seq_pkg, host_ctl_model and the checker are compiled first.
 */
`timescale 1ns/1ps
`include "led_seq_defines.svh"
`define CHK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module tb_led_driver_startup_fault_sequencer;
    import led_seq_pkg::*;
    logic              mclk, rstn, sync_on, dim_req, sync_clk, dim, start_ok, stop_low;
    logic              freq_set_hi, gate_rdy, above_uv, near_ovp, over_i;
    logic              gate_on, sw_en, ss, low_pwr, fault_n, sync_act;
    logic [`LED_N-1:0] in_use, sink_en;
    led_sense_t        sense;
    int                failures, num_checks, lfsr_r, n, exp_use;

    host_ctl_model HOST (.sync_on_in(sync_on), .dim_req_in(dim_req), .sync_clk_out(sync_clk),
        .dim_out(dim));
    led_startup_seq #(.DIM_OFF_TICKS(16'h0010), .SS_TICKS(16'h0020)) DUT (.MCLK_IN(mclk),
        .RSTN_IN(rstn), .SYNC_CLK_IN(sync_clk), .DIM_IN(dim), .SUPPLY_START_OK_IN(start_ok),
        .SUPPLY_STOP_LOW_IN(stop_low), .FREQ_SET_HIGH_IN(freq_set_hi), .GATE_READY_IN(gate_rdy),
        .OUT_ABOVE_UV_IN(above_uv), .OUT_NEAR_OVP_IN(near_ovp), .IN_OVERCURRENT_IN(over_i),
        .LED_SENSE_IN(sense), .GATE_ON_OUT(gate_on), .SWITCH_EN_OUT(sw_en),
        .SOFT_START_OUT(ss), .LOW_POWER_OUT(low_pwr), .FAULT_N_OUT(fault_n),
        .SYNC_ACTIVE_OUT(sync_act), .LED_IN_USE_OUT(in_use), .LED_SINK_EN_OUT(sink_en));

    function automatic int lfsr_next(int v);
        return ((v << 1) | (v[15] ^ v[13] ^ v[12] ^ v[10])) & 32'h0000FFFF;
    endfunction

    task automatic tick(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Bounded wait for an output level; n returns the cycles spent
    task automatic wait_sig(ref logic s, input logic v, input int lim, input string what);
        n = 0;
        while (s !== v && n < lim) begin
            tick(1);
            n++;
        end
        `CHK(what, v, s)
        if (s !== v) final_report();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        {rstn, sync_on, dim_req, start_ok, stop_low, freq_set_hi} = 6'h00;
        {gate_rdy, above_uv, near_ovp, over_i} = 4'h0;
        sense = '0;
        failures = 0;
        num_checks = 0;
        lfsr_r = 77;
        tick(20);
        rstn = 1'b1;
        tick(1);
        `CHK("reset low power", 1'b1, low_pwr)
        `CHK("reset fault flag", 1'b1, fault_n)
        $display("test reset done");
        dim_req = 1'b1;
        start_ok = 1'b1;
        tick(400);
        `CHK("gate held by pin low", 1'b0, gate_on)
        sync_on = 1'b1;
        wait_sig(gate_on, 1'b1, 2000, "gate on with sync");
        `CHK("sinks before check", 4'h0, sink_en)
        `CHK("sync ticks used", 1'b1, sync_act)
        $display("test enable done");
        lfsr_r = lfsr_next(lfsr_r);
        exp_use = (lfsr_r & 32'hF) | 32'h8;
        sense.in_use = exp_use[3:0];
        sense.above_det = 4'hF;
        sense.short_gnd = 4'h1;
        gate_rdy = 1'b1;
        tick(1000);
        `CHK("no progress while shorted", 4'h0, in_use)
        sense.short_gnd = 4'h0;
        n = 0;
        while (in_use === 4'h0 && n < 70000) begin
            tick(1);
            n++;
        end
        `CHK("detect wait", 1'b1, n >= 3000 * 16 && n <= 4000 * 16 + 40)
        if (in_use === 4'h0) final_report();
        `CHK("pins classified", exp_use[3:0], in_use)
        tick(200);
        `CHK("held below uv", 1'b0, sw_en)
        above_uv = 1'b1;
        wait_sig(ss, 1'b1, 20, "soft start");
        `CHK("sinks of used pins", exp_use[3:0], sink_en)
        wait_sig(ss, 1'b0, 32 * 16 + 100, "ramp timeout");
        `CHK("ramp length", 1'b1, n >= 470)
        `CHK("running", 1'b1, sw_en)
        $display("test detect and ramp done");
        above_uv = 1'b0;
        wait_sig(sw_en, 1'b0, 20, "uv stop");
        `CHK("uv not latched", 1'b1, fault_n)
        tick(4);
        above_uv = 1'b1;
        wait_sig(ss, 1'b1, 20, "uv retry");
        near_ovp = 1'b1;
        wait_sig(ss, 1'b0, 20, "near ovp end");
        tick(4);
        near_ovp = 1'b0;
        $display("test output faults done");
        freq_set_hi = 1'b1;
        sync_on = 1'b0;
        wait_sig(sync_act, 1'b0, 1500, "sync fallback");
        `CHK("no fault on open", 1'b1, fault_n)
        `CHK("still switching", 1'b1, sw_en)
        freq_set_hi = 1'b0;
        wait_sig(fault_n, 1'b0, 2500, "held low fault");
        `CHK("switching off", 1'b0, sw_en)
        tick(400);
        `CHK("fault held", 1'b0, fault_n)
        freq_set_hi = 1'b1;
        wait_sig(ss, 1'b1, 30, "restart after release");
        $display("test sync loss done");
        over_i = 1'b1;
        tick(3);
        over_i = 1'b0;
        wait_sig(fault_n, 1'b0, 20, "overcurrent latch");
        tick(300);
        `CHK("latched off", 1'b0, sw_en)
        `CHK("latch held", 1'b0, fault_n)
        dim_req = 1'b0;
        tick(800);
        `CHK("short dimming low", 1'b0, low_pwr)
        tick(2200);
        `CHK("long dimming low", 1'b1, low_pwr)
        `CHK("latch cleared", 1'b1, fault_n)
        start_ok = 1'b0;
        dim_req = 1'b1;
        tick(300);
        `CHK("refused without supply", 1'b1, low_pwr)
        start_ok = 1'b1;
        wait_sig(low_pwr, 1'b0, 500, "restart");
        stop_low = 1'b1;
        wait_sig(low_pwr, 1'b1, 10, "supply cut");
        tick(4);
        stop_low = 1'b0;
        $display("test shutdown done");
        final_report();
    end
endmodule
